// ---- include/segment_mmu_pkg.sv ----
// What this block does
// (RL1) Software writes origin and limit for each used context and segment before RAM use.
// (RL2) Map RAM select only in special cycle with address bit 15 set, 16 clear.
// (RL3) One register per write cycle; context lines pick context, bits 17-23 pick segment.
// (RL4) On register writes, address line 3 picks origin or limit.
// (RL5) With select: buffer enable from t4, write strobe during t3.
// (RL6) Map data direction follows CPU read; registers read back through same path.
// (RL7) Video half reads origin as 12-bit base on 512-byte page boundary.
// (RL8) Origin plus page index bits 9-16, high page nibble forced zero.
// (RL9) Latch translation on base-latch fall; drive only without DMA grant and with mux select.
// (RL10) Second half adds limit count to page; second-nibble carry is limit overflow.
// (RL11) Stack segments invert the limit overflow meaning.
// (RL12) A limit violation suppresses the column strobe; high adder nibble ignored.
// (RL13) Limit upper nibble decodes memory, I/O, write protect and stack flags.
// (RL14) Memory flag (active low) enables column strobe; I/O flag starts peripheral cycle.
// (RL15) Write protect blocks memory writes and special I/O cycle generation.
// (RL16) Stack flag applies a carry shift into the low-order limit adder.
// (RL17) Low nine untranslated address bits form the row address.
// (RL18) Row strobe active after t0 until end of t5, even for I/O or errors.
// (RL19) Row strobe omitted only outside video cycles and first CPU access cycles.
// (RL20) Column strobe enabled for video, DMA in CPU phase, or error-free memory cycle.
// (RL21) Enabled column strobe active after t2 until end of t6.
// (RL22) Two refresh enables, each the exclusive or of video address bits 8 and 11.
// (RL23) Map RAM holds 1024 twelve-bit entries: 4 contexts, 128 segments, origin and limit.
// (RL24) Context from latch, but supervisor function code overrides it.
// (RL25) Base latch sets when address strobe releases; clears at t7 end as CPU phase sets.
// (RL26) Undefined flag combinations are invalid and give no column strobe.
`default_nettype none
package segment_mmu_pkg;
   localparam int unsigned DATA_W = 12;
   localparam int unsigned MAP_DEPTH = 1024;
   localparam int unsigned MAP_ADDR_W = 10;
   localparam int unsigned CONTEXT_W = 2;
   localparam int unsigned SEGMENT_W = 7;
   localparam int unsigned PAGE_W = 8;
   localparam int unsigned ROW_W = 9;
   localparam int unsigned LOG_ADDR_HI = 23;
   localparam int unsigned ROW_LO = 1;
   localparam int unsigned ROW_HI = 9;
   localparam int unsigned PAGE_LO = 9;
   localparam int unsigned PAGE_HI = 16;
   localparam int unsigned SEG_LO = 17;
   localparam int unsigned SEG_HI = 23;
   localparam int unsigned SEL_LINE = 3;
   localparam int unsigned MAPSEL_SET_BIT = 15;
   localparam int unsigned MAPSEL_CLR_BIT = 16;
   // limit register count top bit and upper nibble flags
   localparam int unsigned LIMIT_COUNT_HI = 7;
   localparam int unsigned FLAG_MEM_B = 8;
   localparam int unsigned FLAG_IO = 9;
   localparam int unsigned FLAG_WP = 10;
   localparam int unsigned FLAG_STACK = 11;
   localparam logic [1:0] SUPERVISOR_CONTEXT = 2'h0;
   localparam logic SEL_ORIGIN = 1'b1;
   localparam logic SEL_LIMIT = 1'b0;
   localparam logic [3:0] PAGE_HIGH_NIBBLE = 4'h0;
   localparam logic [11:0] DATA_ZERO = 12'h000;
   typedef enum logic [2:0] {T0, T1, T2, T3, T4, T5, T6, T7} tstate_t;
   localparam tstate_t RAS_FIRST = T1;
   localparam tstate_t RAS_LAST = T5;
   localparam tstate_t CAS_FIRST = T3;
   localparam tstate_t CAS_LAST = T6;
   localparam tstate_t WRITE_STATE = T3;
   localparam tstate_t BUFFER_FIRST = T4;
   localparam tstate_t CHECK_STATE = T1;
   localparam tstate_t DECIDE_STATE = T2;
endpackage
`default_nettype wire

// ---- include/map_ram_if.sv ----
`default_nettype none
interface map_ram_if #(
   parameter int unsigned ADDR_W = 10,
   parameter int unsigned DATA_W = 12
);
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic we;
   logic [DATA_W-1:0] rdata;
   modport ram (input addr, input wdata, input we, output rdata);
   modport user (output addr, output wdata, output we, input rdata);
endinterface
`default_nettype wire

// ---- rtl/map_ram.sv ----
`default_nettype none
module map_ram #(
   parameter int unsigned DEPTH = segment_mmu_pkg::MAP_DEPTH,
   parameter int unsigned ADDR_W = segment_mmu_pkg::MAP_ADDR_W,
   parameter int unsigned DATA_W = segment_mmu_pkg::DATA_W
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   map_ram_if.ram bus
);
   import segment_mmu_pkg::*;

   typedef struct packed {
      logic [DATA_W-1:0] rdata;
   } ram_state_t;

   // contents undefined after power-on until software loads them
   logic [DATA_W-1:0] mem [DEPTH];
   ram_state_t state;
   ram_state_t next_state;

   if (DEPTH != (1 << ADDR_W)) begin : g_bad_depth
      $error("map_ram depth must equal two to the address width");
   end

   always_comb begin
      next_state = state;
      next_state.rdata = mem[bus.addr];
   end

   always_ff @(posedge sys_clk) begin
      if (bus.we) begin
         mem[bus.addr] <= bus.wdata; // see (RL23)
      end
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= '0;
      end else begin
         state <= next_state;
      end
   end

   assign bus.rdata = state.rdata;
endmodule // map_ram
`default_nettype wire

// ---- rtl/segment_mmu_memory_timing.sv ----
`default_nettype none
module segment_mmu_memory_timing #(
   parameter int unsigned CONTEXTS = 4,
   parameter int unsigned SEGMENTS = 128
) (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [segment_mmu_pkg::LOG_ADDR_HI:1] cpu_addr,
   input wire logic cpu_as_b,
   input wire logic cpu_read,
   input wire logic special_space_cycle,
   input wire logic supervisor_function_code,
   input wire logic context_select_bit_a,
   input wire logic context_select_bit_b,
   input wire logic dma_grant_ack_b,
   input wire logic video_address_mux_select,
   input wire logic cpu_access_first,
   input wire logic video_address_bit_eight,
   input wire logic video_address_bit_eleven,
   input wire logic [segment_mmu_pkg::DATA_W-1:0] map_data_i,
   output logic [segment_mmu_pkg::DATA_W-1:0] map_data_o,
   output logic map_data_oe_b,
   output logic map_ram_select,
   output logic map_data_buffer_enable,
   output logic map_ram_write_strobe,
   output logic [segment_mmu_pkg::ROW_W-1:0] row_addr,
   output logic [segment_mmu_pkg::DATA_W-1:0] phys_addr,
   output logic phys_addr_oe_b,
   output logic ras_b,
   output logic cas_b,
   output logic cpu_phase_flop,
   output logic base_phase_latch_enable,
   output logic limit_overflow,
   output logic limit_violation,
   output logic write_protect_flag,
   output logic stack_segment_flag,
   output logic peripheral_cycle_flop,
   output logic special_cycle_enable,
   output logic memory_read_request,
   output logic refresh_enable_a,
   output logic refresh_enable_b
);
   import segment_mmu_pkg::*;

   if (CONTEXTS * SEGMENTS * 2 != MAP_DEPTH || SEGMENTS != (1 << SEGMENT_W)
       || CONTEXTS != (1 << CONTEXT_W)) begin : g_bad_geometry
      $error("context and segment counts must fill the map RAM exactly");
   end

   typedef struct packed {
      tstate_t tstate;
      logic cpu_phase;
      logic base_latch;
      logic as_prev;
      logic [DATA_W-1:0] phys;
      logic phys_oe_b;
      logic [ROW_W-1:0] row;
      logic ras_b;
      logic cas_b;
      logic cas_en;
      logic overflow;
      logic violation;
      logic mem_ok;
      logic io_ok;
      logic wp;
      logic stack;
      logic error_free;
      logic periph;
      logic special_en;
      logic map_sel;
      logic buf_en;
      logic wr_strobe;
      logic [DATA_W-1:0] map_out;
      logic map_oe_b;
      logic mem_read;
      logic refresh_a;
      logic refresh_b;
   } mmu_state_t;

   mmu_state_t state;
   mmu_state_t next_state;

   map_ram_if #(.ADDR_W(MAP_ADDR_W), .DATA_W(DATA_W)) ram_bus ();

   map_ram #(
      .DEPTH(MAP_DEPTH),
      .ADDR_W(MAP_ADDR_W),
      .DATA_W(DATA_W)
   ) u_map_ram (
      .sys_clk(sys_clk),
      .rst_b(rst_b),
      .bus(ram_bus)
   );

   logic sel_decode;
   logic [CONTEXT_W-1:0] context_now;
   logic base_limit_sel;
   logic [PAGE_W-1:0] page;
   logic [DATA_W-1:0] origin_sum;
   logic [PAGE_W:0] limit_sum;
   logic [3:0] flags;
   logic flag_mem;
   logic flag_io;
   logic flag_wp;
   logic flag_stack;
   logic flags_valid;
   logic carry_out;
   logic cpu_write;

   always_comb begin
      sel_decode = special_space_cycle && cpu_addr[MAPSEL_SET_BIT]
                   && !cpu_addr[MAPSEL_CLR_BIT]; // see (RL2)
      // supervisor mode overrides the software context latch
      if (supervisor_function_code) begin
         context_now = SUPERVISOR_CONTEXT; // see (RL24)
      end else begin
         context_now = {context_select_bit_b, context_select_bit_a};
      end
      // register access picks the half by line 3, translation by phase
      if (sel_decode) begin
         base_limit_sel = cpu_addr[SEL_LINE]; // see (RL4)
      end else begin
         base_limit_sel = state.base_latch ? SEL_ORIGIN : SEL_LIMIT; // see (RL25)
      end
      ram_bus.addr = {context_now, cpu_addr[SEG_HI:SEG_LO], base_limit_sel}; // see (RL3)
      ram_bus.wdata = map_data_i; // see (RL6)
      ram_bus.we = state.wr_strobe;
   end

   always_comb begin
      page = cpu_addr[PAGE_HI:PAGE_LO];
      cpu_write = !cpu_read;
      origin_sum = ram_bus.rdata + {PAGE_HIGH_NIBBLE, page}; // see (RL7) see (RL8)
      flags = ram_bus.rdata[FLAG_STACK:FLAG_MEM_B]; // see (RL13)
      flag_mem = !flags[0]; // see (RL14)
      flag_io = flags[FLAG_IO - FLAG_MEM_B];
      flag_wp = flags[FLAG_WP - FLAG_MEM_B];
      flag_stack = flags[FLAG_STACK - FLAG_MEM_B];
      // the high adder nibble is not used in the limit phase
      limit_sum = {1'b0, ram_bus.rdata[LIMIT_COUNT_HI:0]} + {1'b0, page}
                  + {{PAGE_W{1'b0}}, flag_stack}; // see (RL10) see (RL16) see (RL12)
      carry_out = limit_sum[PAGE_W];
      flags_valid = !(flag_mem && flag_io) && !(flag_io && flag_stack); // see (RL26)
   end

   always_comb begin
      next_state = state;
      next_state.as_prev = cpu_as_b;
      next_state.row = cpu_addr[ROW_HI:ROW_LO]; // see (RL17)

      unique case (state.tstate)
         T0: next_state.tstate = T1;
         T1: next_state.tstate = T2;
         T2: next_state.tstate = T3;
         T3: next_state.tstate = T4;
         T4: next_state.tstate = T5;
         T5: next_state.tstate = T6;
         T6: next_state.tstate = T7;
         T7: next_state.tstate = T0;
      endcase

      // video and cpu halves alternate, each eight states long
      if (state.tstate == T7) begin
         next_state.cpu_phase = !state.cpu_phase;
         if (!state.cpu_phase) begin
            next_state.base_latch = 1'b0; // see (RL25)
         end
         next_state.periph = 1'b0;
      end
      if (!state.as_prev && cpu_as_b) begin
         next_state.base_latch = 1'b1; // see (RL25)
      end

      // translated base captured as the origin phase ends
      if (state.base_latch && !next_state.base_latch) begin
         next_state.phys = origin_sum; // see (RL9)
      end
      next_state.phys_oe_b = !(dma_grant_ack_b && video_address_mux_select); // see (RL9)

      // limit read out in the cpu half; data valid one state after address
      if (state.cpu_phase && state.tstate == CHECK_STATE && !state.map_sel) begin
         next_state.overflow = carry_out; // see (RL10)
         next_state.violation = carry_out ^ flag_stack; // see (RL11)
         next_state.mem_ok = flag_mem && flags_valid;
         next_state.io_ok = flag_io && flags_valid;
         next_state.wp = flag_wp;
         next_state.stack = flag_stack;
         next_state.error_free = flag_mem && flags_valid && !(cpu_write && flag_wp)
                                 && !(carry_out ^ flag_stack); // see (RL20) see (RL15) see (RL12)
      end
      next_state.special_en = special_space_cycle && !state.wp; // see (RL15)

      if (state.tstate == DECIDE_STATE) begin
         next_state.cas_en = !state.cpu_phase
                             || (state.cpu_phase && !dma_grant_ack_b)
                             || (state.cpu_phase && state.error_free); // see (RL20) see (RL14)
         if (state.cpu_phase && state.io_ok) begin
            next_state.periph = 1'b1; // see (RL14)
         end
      end

      // strobes are registered for the state being entered
      next_state.ras_b = !((!next_state.cpu_phase || cpu_access_first)
                           && next_state.tstate >= RAS_FIRST
                           && next_state.tstate <= RAS_LAST); // see (RL18) see (RL19)
      next_state.cas_b = !(next_state.cas_en
                           && next_state.tstate >= CAS_FIRST
                           && next_state.tstate <= CAS_LAST); // see (RL21) see (RL12)
      next_state.mem_read = state.cpu_phase ? (cpu_read && state.error_free) : 1'b1;

      // mapping register access in special space
      next_state.map_sel = sel_decode; // see (RL2)
      next_state.buf_en = sel_decode && next_state.tstate >= BUFFER_FIRST; // see (RL5)
      next_state.wr_strobe = sel_decode && cpu_write
                             && next_state.tstate == WRITE_STATE; // see (RL5) see (RL3)
      if (state.map_sel && cpu_read) begin
         next_state.map_out = ram_bus.rdata; // see (RL6)
      end
      next_state.map_oe_b = !(sel_decode && cpu_read && next_state.buf_en); // see (RL6)

      next_state.refresh_a = video_address_bit_eight ^ video_address_bit_eleven; // see (RL22)
      next_state.refresh_b = video_address_bit_eight ^ video_address_bit_eleven; // see (RL22)
   end

   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         state <= '{
            tstate: T0,
            cpu_phase: 1'b0,
            base_latch: 1'b0,
            as_prev: 1'b1,
            phys: DATA_ZERO,
            phys_oe_b: 1'b1,
            row: '0,
            ras_b: 1'b1,
            cas_b: 1'b1,
            cas_en: 1'b0,
            overflow: 1'b0,
            violation: 1'b0,
            mem_ok: 1'b0,
            io_ok: 1'b0,
            wp: 1'b0,
            stack: 1'b0,
            error_free: 1'b0,
            periph: 1'b0,
            special_en: 1'b0,
            map_sel: 1'b0,
            buf_en: 1'b0,
            wr_strobe: 1'b0,
            map_out: DATA_ZERO,
            map_oe_b: 1'b1,
            mem_read: 1'b0,
            refresh_a: 1'b0,
            refresh_b: 1'b0
         };
      end else begin
         state <= next_state;
      end
   end

   assign map_data_o = state.map_out;
   assign map_data_oe_b = state.map_oe_b;
   assign map_ram_select = state.map_sel;
   assign map_data_buffer_enable = state.buf_en;
   assign map_ram_write_strobe = state.wr_strobe;
   assign row_addr = state.row;
   assign phys_addr = state.phys;
   assign phys_addr_oe_b = state.phys_oe_b;
   assign ras_b = state.ras_b;
   assign cas_b = state.cas_b;
   assign cpu_phase_flop = state.cpu_phase;
   assign base_phase_latch_enable = state.base_latch;
   assign limit_overflow = state.overflow;
   assign limit_violation = state.violation;
   assign write_protect_flag = state.wp;
   assign stack_segment_flag = state.stack;
   assign peripheral_cycle_flop = state.periph;
   assign special_cycle_enable = state.special_en;
   assign memory_read_request = state.mem_read;
   assign refresh_enable_a = state.refresh_a;
   assign refresh_enable_b = state.refresh_b;
endmodule // segment_mmu_memory_timing
`default_nettype wire

// ---- sim/segment_mmu_checker_sva.sv ----
`default_nettype none
module segment_mmu_checker (
   input wire logic sys_clk,
   input wire logic rst_b,
   input wire logic [segment_mmu_pkg::LOG_ADDR_HI:1] cpu_addr,
   input wire logic special_space_cycle,
   input wire logic video_address_bit_eight,
   input wire logic video_address_bit_eleven,
   input wire logic map_ram_select,
   input wire logic map_data_buffer_enable,
   input wire logic map_ram_write_strobe,
   input wire logic ras_b,
   input wire logic cas_b,
   input wire logic base_phase_latch_enable,
   input wire logic limit_overflow,
   input wire logic limit_violation,
   input wire logic stack_segment_flag,
   input wire logic write_protect_flag,
   input wire logic special_cycle_enable,
   input wire logic refresh_enable_a,
   input wire logic refresh_enable_b
);
   timeunit 1ns;
   timeprecision 1ps;
   import segment_mmu_pkg::*;
   // mirror of the t-state counter and the half it belongs to
   logic [2:0] ts;
   logic ph;
   always_ff @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ts <= 3'h0;
         ph <= 1'b0;
      end else begin
         ts <= ts + 3'h1;
         ph <= ph ^ (ts == 3'h7);
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   sequence s_write;
      map_ram_write_strobe && !map_data_buffer_enable ##1 !map_ram_write_strobe && map_data_buffer_enable;
   endsequence
   map_sel_decode_a: assert property (map_ram_select |-> $past(special_space_cycle) && $past(cpu_addr[15])
      && !$past(cpu_addr[16])) else $error("map select without decode");
   strobe_state_a: assert property (map_ram_write_strobe |-> ts == WRITE_STATE && map_ram_select)
      else $error("write strobe outside t3");
   write_walk_a: assert property ($rose(map_ram_write_strobe) |-> s_write)
      else $error("write strobe not followed by buffer enable");
   buffer_state_a: assert property (map_data_buffer_enable |-> map_ram_select && ts >= BUFFER_FIRST)
      else $error("buffer enable before t4");
   ras_idle_a: assert property ((ts == T0 || ts > RAS_LAST) |-> ras_b)
      else $error("row strobe outside t1 to t5");
   video_strobe_a: assert property ((!ph && ts >= CAS_FIRST && ts <= RAS_LAST) |-> !ras_b && !cas_b)
      else $error("video cycle strobes missing");
   cas_idle_a: assert property ((ts < CAS_FIRST || ts > CAS_LAST) |-> cas_b)
      else $error("column strobe outside t3 to t6");
   viol_xor_a: assert property (limit_violation == (limit_overflow ^ stack_segment_flag))
      else $error("violation not overflow xor stack");
   refresh_xor_a: assert property (1'b1 |=> refresh_enable_a ==
      ($past(video_address_bit_eight) ^ $past(video_address_bit_eleven)) && refresh_enable_b == refresh_enable_a)
      else $error("refresh enable wrong");
   base_clear_a: assert property ((ts == T7 && !ph) |=> !base_phase_latch_enable)
      else $error("base latch not cleared after video t7");
   special_gate_a: assert property (1'b1 |=> special_cycle_enable ==
      ($past(special_space_cycle) && !$past(write_protect_flag)))
      else $error("special cycle not gated by write protect");
endmodule // segment_mmu_checker
`default_nettype wire

// ---- sim/cpu_bus_model.sv ----
`default_nettype none
module cpu_bus_model (
   input wire logic sys_clk,
   input wire logic rst_b,
   output logic [segment_mmu_pkg::LOG_ADDR_HI:1] cpu_addr,
   output logic cpu_as_b,
   output logic cpu_read,
   output logic special_space_cycle,
   output logic supervisor_function_code,
   output logic [1:0] ctx,
   output logic dma_grant_ack_b,
   output logic video_address_mux_select,
   output logic cpu_access_first,
   output logic [segment_mmu_pkg::DATA_W-1:0] map_data_i
);
   timeunit 1ns;
   timeprecision 1ps;
   import segment_mmu_pkg::*;
   logic [2:0] ts;
   logic ph;
   bit late = 1'b0;
   initial begin
      {cpu_addr, cpu_read, special_space_cycle, supervisor_function_code, ctx, map_data_i} = '0;
      {cpu_as_b, dma_grant_ack_b, video_address_mux_select, cpu_access_first} = 4'hf;
   end
   always @(posedge sys_clk or negedge rst_b) begin
      if (!rst_b) begin
         ts <= 3'h0;
         ph <= 1'b0;
      end else begin
         ts <= ts + 3'h1;
         ph <= ph ^ (ts == 3'h7);
      end
   end
   // returns just after the edge that ends state s of half p
   task automatic wait_for(input logic [2:0] s, input logic p);
      bit hit;
      hit = 1'b0;
      for (int n = 0; n < 40 && !hit; n++) begin
         @(posedge sys_clk);
         hit = (ts == s && ph == p);
      end
      late |= !hit;
   endtask
   // one register per 8-state cycle, inputs held throughout
   task automatic map_access(input logic [1:0] c, input logic [6:0] seg, input logic sel, input logic rd,
         input logic [11:0] wd, input logic sv, input logic bad);
      wait_for(3'h7, ph);
      cpu_addr <= {seg, bad, 1'b1, 11'h000, sel, 2'h0};
      {ctx, supervisor_function_code, cpu_read, map_data_i, special_space_cycle} <= {c, sv, rd, wd, 1'b1};
      @(posedge sys_clk);
      wait_for(3'h6, ph);
   endtask
   // strobe released mid video half; map data lines inverted as well
   task automatic xlate(input logic [1:0] c, input logic [LOG_ADDR_HI:1] a, input logic [3:0] mode);
      wait_for(3'h7, 1'b1);
      {special_space_cycle, supervisor_function_code, ctx, cpu_addr, cpu_as_b} <= {2'h0, c, a, 1'b0};
      {cpu_read, cpu_access_first, dma_grant_ack_b, video_address_mux_select} <= mode;
      map_data_i <= ~map_data_i;
      wait_for(3'h2, 1'b0);
      cpu_as_b <= 1'b1;
      wait_for(3'h7, 1'b0);
   endtask
endmodule // cpu_bus_model
`default_nettype wire

// ---- sim/segment_mmu_memory_timing_tb.sv ----
`default_nettype none
module segment_mmu_memory_timing_tb;
   timeunit 1ns;
   timeprecision 1ps;
   import segment_mmu_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [LOG_ADDR_HI:1] cpu_addr, a;
   logic cpu_as_b, cpu_read, special_space_cycle, supervisor_function_code, dma_grant_ack_b, first, mux_sel;
   logic [1:0] ctx, vbits = 2'h0;
   logic [11:0] map_data_i, map_data_o, phys_addr, org, lim;
   logic [8:0] row_addr;
   logic map_data_oe_b, map_ram_select, phys_addr_oe_b, ras_b, cas_b, limit_violation, write_protect_flag;
   logic stack_segment_flag, peripheral_cycle_flop, cpu_ph, mem_rd;
   logic [11:0] val [8];
   logic [1:0] ec [8];
   logic [6:0] es [8];
   logic [3:0] md;
   logic [2:0] e;
   integer seed = 32'h8a0d_726e;
   int mismatches = 0;
   int total_checks = 0;
   int i;
   segment_mmu_memory_timing DUT (.sys_clk(sys_clk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_as_b(cpu_as_b),
      .cpu_read(cpu_read), .special_space_cycle(special_space_cycle),
      .supervisor_function_code(supervisor_function_code), .context_select_bit_a(ctx[0]),
      .context_select_bit_b(ctx[1]), .dma_grant_ack_b(dma_grant_ack_b), .video_address_mux_select(mux_sel),
      .cpu_access_first(first), .video_address_bit_eight(vbits[0]), .video_address_bit_eleven(vbits[1]),
      .map_data_i(map_data_i), .map_data_o(map_data_o), .map_data_oe_b(map_data_oe_b),
      .map_ram_select(map_ram_select), .map_data_buffer_enable(), .map_ram_write_strobe(), .row_addr(row_addr),
      .phys_addr(phys_addr), .phys_addr_oe_b(phys_addr_oe_b), .ras_b(ras_b), .cas_b(cas_b), .cpu_phase_flop(cpu_ph),
      .base_phase_latch_enable(), .limit_overflow(), .limit_violation(limit_violation),
      .write_protect_flag(write_protect_flag), .stack_segment_flag(stack_segment_flag),
      .peripheral_cycle_flop(peripheral_cycle_flop), .special_cycle_enable(), .memory_read_request(mem_rd),
      .refresh_enable_a(), .refresh_enable_b());
   cpu_bus_model cpu (.sys_clk(sys_clk), .rst_b(rst_b), .cpu_addr(cpu_addr), .cpu_as_b(cpu_as_b),
      .cpu_read(cpu_read), .special_space_cycle(special_space_cycle),
      .supervisor_function_code(supervisor_function_code), .ctx(ctx), .dma_grant_ack_b(dma_grant_ack_b),
      .video_address_mux_select(mux_sel), .cpu_access_first(first), .map_data_i(map_data_i));
   initial begin
      forever #10 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      vbits <= 2'($random(seed));
   end
   task automatic check(input string what, input logic [11:0] exp, input logic [11:0] got);
      total_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, mismatches);
      if (mismatches == 0 && total_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   task automatic report(input string name);
      check("wait bound", 12'h000, cpu.late);
      $display("test %s done: %0d checks, %0d mismatches", name, total_checks, mismatches);
      if (cpu.late) begin
         summarize();
      end
   endtask
   // {column strobe on, violation, peripheral cycle}
   function automatic logic [2:0] expect_limit(input logic [11:0] l, input logic [7:0] pg, input logic rd,
         input logic dma_b);
      logic [8:0] sum;
      logic ok;
      logic viol;
      sum = {1'b0, l[7:0]} + {1'b0, pg} + 9'(l[FLAG_STACK]);
      viol = sum[8] ^ l[FLAG_STACK];
      ok = !(!l[FLAG_MEM_B] && l[FLAG_IO]) && !(l[FLAG_IO] && l[FLAG_STACK]);
      return {!dma_b || (!l[FLAG_MEM_B] && ok && !(!rd && l[FLAG_WP]) && !viol), viol, l[FLAG_IO] && ok};
   endfunction
   initial begin
      repeat (3) @(posedge sys_clk);
      rst_b <= 1'b1;
      #1;
      check("reset outputs", 12'h01e, {ras_b, cas_b, map_data_oe_b, phys_addr_oe_b, map_ram_select});
      for (i = 0; i < 8; i++) begin
         if (!i[0]) begin
            ec[i] = (i == 6) ? 2'h3 : (i == 0) ? 2'h0 : 2'($random(seed));
            es[i] = (i == 6) ? 7'h7f : {2'(i / 2), (i == 0) ? 5'h00 : 5'($random(seed))};
         end else begin
            ec[i] = ec[i - 1];
            es[i] = es[i - 1];
         end
         val[i] = 12'($random(seed));
         cpu.map_access(ec[i], es[i], i[0], 1'b0, val[i], 1'b0, 1'b0);
      end
      cpu.map_access(2'h0, 7'h00, 1'b0, 1'b0, ~val[0], 1'b0, 1'b1);
      check("map select", 12'h000, map_ram_select);
      for (i = 0; i < 8; i++) begin
         cpu.map_access((i == 0) ? 2'h3 : ec[i], es[i], i[0], 1'b1, 12'h000, i == 0, 1'b0);
         check("map readback", val[i], map_data_o);
         check("readback drive", 12'h000, map_data_oe_b);
      end
      report("map registers");
      for (i = 0; i < 16; i++) begin
         a = 23'($random(seed));
         org = 12'($random(seed));
         lim = {4'(i), 8'($random(seed))};
         if (i % 4 == 1) lim[7:0] = ~a[16:9];
         if (i % 4 == 2) lim[7:0] = 8'h00 - a[16:9];
         md = 4'($random(seed));
         md[1] = (i % 8 != 5);
         cpu.map_access(2'(i), a[23:17], SEL_ORIGIN, 1'b0, org, 1'b0, 1'b0);
         cpu.map_access(2'(i), a[23:17], SEL_LIMIT, 1'b0, lim, 1'b0, 1'b0);
         cpu.xlate(2'(i), a, md);
         #1;
         check("phys_addr", org + {4'h0, a[16:9]}, phys_addr);
         cpu.wait_for(3'h3, 1'b1);
         #1;
         e = expect_limit(lim, a[16:9], md[3], md[1]);
         check("cas_b", !e[2], cas_b);
         check("violation", e[1], limit_violation);
         check("io cycle", e[0], peripheral_cycle_flop);
         check("ras_b", !md[2], ras_b);
         check("row_addr", a[9:1], row_addr);
         check("addr drive", !(md[1] && md[0]), phys_addr_oe_b);
         check("type flags", lim[11:10], {stack_segment_flag, write_protect_flag});
         check("cpu half", 1'b1, cpu_ph);
         e = expect_limit(lim, a[16:9], md[3], 1'b1);
         check("read request", md[3] && e[2], mem_rd);
      end
      report("translation");
      summarize();
   end
endmodule // segment_mmu_memory_timing_tb
bind segment_mmu_memory_timing segment_mmu_checker chk (.sys_clk(sys_clk), .rst_b(rst_b), .cpu_addr(cpu_addr),
   .special_space_cycle(special_space_cycle), .video_address_bit_eight(video_address_bit_eight),
   .video_address_bit_eleven(video_address_bit_eleven), .map_ram_select(map_ram_select),
   .map_data_buffer_enable(map_data_buffer_enable), .map_ram_write_strobe(map_ram_write_strobe),
   .ras_b(ras_b), .cas_b(cas_b), .base_phase_latch_enable(base_phase_latch_enable),
   .limit_overflow(limit_overflow), .limit_violation(limit_violation), .stack_segment_flag(stack_segment_flag),
   .write_protect_flag(write_protect_flag), .special_cycle_enable(special_cycle_enable),
   .refresh_enable_a(refresh_enable_a), .refresh_enable_b(refresh_enable_b));
`default_nettype wire
